// ### hw/wait_interlock_pkg.sv
// constants, field layouts and carrier types of the automatic-cycle wait interlock
package wait_interlock_pkg;
  // -------------------------------------------------------------------
  // register map (byte addresses, one 32-bit word each)
  // -------------------------------------------------------------------
  localparam int          ADDR_W          = 8;
  localparam logic [7:0]  OFF_AUX_CFG     = 8'h00;
  localparam logic [7:0]  OFF_LOCK_CFG    = 8'h04;
  localparam logic [7:0]  OFF_BLOCK_CMD   = 8'h08;
  localparam logic [7:0]  OFF_DWELL_TIME  = 8'h0C;
  localparam logic [7:0]  OFF_INPOS_WIDTH = 8'h10;
  localparam logic [7:0]  OFF_FEED_CMD    = 8'h14;
  localparam logic [7:0]  OFF_STATUS      = 8'h18;
  localparam logic [7:0]  OFF_OVERRIDE    = 8'h1C;
  localparam logic [31:0] RST_WORD        = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
  // -------------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------------
  localparam int AUX_KIND_BIT    = 7;
  localparam int GLOBAL_SEL_BIT  = 0;
  localparam int FAST_SEL_BIT    = 1;
  localparam int AXIS_SEL_BIT    = 2;
  localparam int DIR_SEL_BIT     = 3;
  localparam int CMD_KIND_LSB    = 0;
  localparam int CMD_SEL_LSB     = 2;
  localparam int SEL_M           = 0;
  localparam int SEL_S           = 1;
  localparam int SEL_T           = 2;
  localparam int ACK_BIT         = 3;
  localparam int STB_M_BIT       = 0;
  localparam int STB_S_BIT       = 2;
  localparam int STB_T_BIT       = 3;
  localparam int GLOBAL_LOCK_BIT = 0;
  localparam int FAST_LOCK_BIT   = 6;
  localparam int FLAG_AUX        = 0;
  localparam int FLAG_MOTION     = 1;
  localparam int FLAG_DWELL      = 2;
  localparam int FLAG_INPOS      = 3;
  localparam int FLAG_OVR_ZERO   = 4;
  localparam int FLAG_LOCK       = 5;
  localparam int FLAG_SPINDLE    = 6;
  localparam int FLAG_JOG_ZERO   = 7;
  localparam int FLAG_RESET      = 8;
  localparam int FLAG_W          = 9;
  localparam int STAT_RUN_BIT    = 16;
  localparam int OVR_PCT_LSB     = 0;
  localparam int OVR_FEED_LSB    = 8;
  // -------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------
  localparam int CLK_HZ         = 10_000_000;
  localparam int DWELL_UNIT_US  = 1000;
  localparam int DWELL_UNIT_CYC = (CLK_HZ / 1_000_000) * DWELL_UNIT_US;
  // -------------------------------------------------------------------
  // types
  // -------------------------------------------------------------------
  typedef enum logic [1:0] {
    KIND_FEED  = 2'h0,
    KIND_POS   = 2'h1,
    KIND_DWELL = 2'h2,
    KIND_AUX   = 2'h3
  } block_kind_type;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_AUX    = 3'h1,
    ST_MOTION = 3'h2,
    ST_INPOS  = 3'h3,
    ST_DWELL  = 3'h4
  } cycle_state_type;

  // machine-logic side input bytes, all asynchronous to ref_clk
  typedef struct packed {
    logic [7:0] ack_byte;
    logic [7:0] done_toggle_byte;
    logic [7:0] global_lock_byte;
    logic [7:0] fast_lock_byte;
    logic [7:0] axis_lock_n;
    logic [7:0] axis_dir_lock_plus;
    logic [7:0] axis_dir_lock_minus;
    logic [7:0] feed_override_n;
    logic       spindle_at_speed;
    logic       jog_override_zero;
    logic       reset_active;
  } pin_in_type;

  typedef struct packed {
    logic [1:0] plus;
    logic [1:0] minus;
  } axis_permit_type;
endpackage

// ### hw/auto_cycle_wait_interlock.sv
// automatic-cycle sequencer with aux handshake, interlocks, override and axi4-lite registers
//
// Overview of operation
// [R1] one wait-reason flag per blocking cause
// [R2] config bit 7 picks level or toggle handshake
// [R3] level mode: ack falling edge ends aux
// [R4] m, s, t strobes on bits 0, 2, 3
// [R5] partner drives done toggles bits 0, 2, 3
// [R6] toggle mode: done equals strobe ends aux
// [R7] positioning waits for error within in-position width
// [R8] dwell is a timed wait, flagged while running
// [R9] active-low override byte scales programmed feed
// [R10] lock config bit 1 enables fast lock; bits 0, 2, 3 disable global, axis and direction locks
// [R11] global lock low blocks all motion
// [R12] fast lock bit 6 low blocks motion
// [R13] per-axis lock low blocks that axis
// [R14] running status and cycle indicator while active
// [R15] direction lock high blocks that direction
// [R16] override percent is complement of inputs
// [R17] flags follow their condition in same cycle
`timescale 1ns/10ps
module auto_cycle_wait_interlock #(
  parameter int DWELL_UNIT_CYCLES = wait_interlock_pkg::DWELL_UNIT_CYC,
  parameter int ERR_W             = 16
) (
  input  wire logic                              ref_clk,
  input  wire logic                              srst,
  input  wire logic [wait_interlock_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                              s_axi_awvalid,
  output logic                                   s_axi_awready,
  input  wire logic [31:0]                       s_axi_wdata,
  input  wire logic [3:0]                        s_axi_wstrb,
  input  wire logic                              s_axi_wvalid,
  output logic                                   s_axi_wready,
  output logic [1:0]                             s_axi_bresp,
  output logic                                   s_axi_bvalid,
  input  wire logic                              s_axi_bready,
  input  wire logic [wait_interlock_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                              s_axi_arvalid,
  output logic                                   s_axi_arready,
  output logic [31:0]                            s_axi_rdata,
  output logic [1:0]                             s_axi_rresp,
  output logic                                   s_axi_rvalid,
  input  wire logic                              s_axi_rready,
  input  wire wait_interlock_pkg::pin_in_type    pins,
  input  wire logic                              motion_done,
  input  wire logic [1:0][ERR_W-1:0]             pos_err,
  output logic [7:0]                             code_strobe_byte,
  output wait_interlock_pkg::axis_permit_type    axis_permit,
  output logic                                   motion_active,
  output logic [23:0]                            feed_scaled,
  output logic                                   running_indicator
);
  import wait_interlock_pkg::*;

  // -------------------------------------------------------------------
  // input synchroniser
  // -------------------------------------------------------------------
  pin_in_type      pin_meta_reg;
  pin_in_type      pin_reg;

  always_ff @(posedge ref_clk) begin
    pin_meta_reg <= pins;
    pin_reg      <= pin_meta_reg;
  end

  // -------------------------------------------------------------------
  // register state
  // -------------------------------------------------------------------
  logic [31:0]     aux_cfg_reg, aux_cfg_next;
  logic [31:0]     lock_cfg_reg, lock_cfg_next;
  logic [31:0]     dwell_time_reg, dwell_time_next;
  logic [31:0]     inpos_width_reg, inpos_width_next;
  logic [31:0]     feed_cmd_reg, feed_cmd_next;
  logic [31:0]     block_cmd_reg, block_cmd_next;
  logic            aw_held_reg, aw_held_next;
  logic            w_held_reg, w_held_next;
  logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
  logic [31:0]     w_data_reg, w_data_next;
  logic [3:0]      w_strb_reg, w_strb_next;
  logic            bvalid_reg, bvalid_next;
  logic [1:0]      bresp_reg, bresp_next;
  logic            rvalid_reg, rvalid_next;
  logic [1:0]      rresp_reg, rresp_next;
  logic [31:0]     rdata_reg, rdata_next;
  logic            start_pulse;
  logic [FLAG_W-1:0] wait_flags;
  logic [7:0]      ovr_pct;
  cycle_state_type state_reg;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
  assign s_axi_wready  = ~w_held_reg & ~bvalid_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

  // -------------------------------------------------------------------
  // axi4-lite slave
  // -------------------------------------------------------------------
  always_comb begin
    logic            do_write;
    logic [ADDR_W-1:0] wa;
    logic [31:0]     wd;
    logic [3:0]      ws;
    do_write         = 1'b0;
    wa               = aw_addr_reg;
    wd               = w_data_reg;
    ws               = w_strb_reg;
    aux_cfg_next     = aux_cfg_reg;
    lock_cfg_next    = lock_cfg_reg;
    dwell_time_next  = dwell_time_reg;
    inpos_width_next = inpos_width_reg;
    feed_cmd_next    = feed_cmd_reg;
    block_cmd_next   = block_cmd_reg;
    aw_held_next     = aw_held_reg;
    w_held_next      = w_held_reg;
    aw_addr_next     = aw_addr_reg;
    w_data_next      = w_data_reg;
    w_strb_next      = w_strb_reg;
    bvalid_next      = bvalid_reg;
    bresp_next       = bresp_reg;
    rvalid_next      = rvalid_reg;
    rresp_next       = rresp_reg;
    rdata_next       = rdata_reg;
    start_pulse      = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
      wa           = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
      wd          = s_axi_wdata;
      ws          = s_axi_wstrb;
    end
    if (aw_held_next && w_held_next && !bvalid_reg) begin
      do_write     = 1'b1;
      aw_held_next = 1'b0;
      w_held_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = RESP_OKAY;
    end
    if (do_write) begin
      case ({wa[ADDR_W-1:2], 2'b00})
        OFF_AUX_CFG:     aux_cfg_next     = merge(aux_cfg_reg, wd, ws);
        OFF_LOCK_CFG:    lock_cfg_next    = merge(lock_cfg_reg, wd, ws);
        OFF_DWELL_TIME:  dwell_time_next  = merge(dwell_time_reg, wd, ws);
        OFF_INPOS_WIDTH: inpos_width_next = merge(inpos_width_reg, wd, ws);
        OFF_FEED_CMD:    feed_cmd_next    = merge(feed_cmd_reg, wd, ws);
        OFF_BLOCK_CMD: begin
          // a new block is only taken while the cycle is idle
          if (state_reg == ST_IDLE) begin
            block_cmd_next = merge(block_cmd_reg, wd, ws);
            start_pulse    = 1'b1;
          end
        end
        OFF_STATUS, OFF_OVERRIDE: bresp_next = RESP_OKAY;
        default: bresp_next = RESP_SLVERR;
      endcase
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next  = RESP_OKAY;
      rdata_next  = RST_WORD;
      case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
        OFF_AUX_CFG:     rdata_next = aux_cfg_reg;
        OFF_LOCK_CFG:    rdata_next = lock_cfg_reg;
        OFF_BLOCK_CMD:   rdata_next = block_cmd_reg;
        OFF_DWELL_TIME:  rdata_next = dwell_time_reg;
        OFF_INPOS_WIDTH: rdata_next = inpos_width_reg;
        OFF_FEED_CMD:    rdata_next = feed_cmd_reg;
        OFF_STATUS: begin
          rdata_next[FLAG_W-1:0]   = wait_flags; // R1
          rdata_next[STAT_RUN_BIT] = running_indicator; // R14
        end
        OFF_OVERRIDE: begin
          rdata_next[OVR_PCT_LSB +: 8]   = ovr_pct;
          rdata_next[OVR_FEED_LSB +: 24] = feed_scaled;
        end
        default: rresp_next = RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      aux_cfg_reg     <= RST_WORD;
      lock_cfg_reg    <= RST_WORD;
      dwell_time_reg  <= RST_WORD;
      inpos_width_reg <= RST_WORD;
      feed_cmd_reg    <= RST_WORD;
      block_cmd_reg   <= RST_WORD;
      aw_held_reg     <= 1'b0;
      w_held_reg      <= 1'b0;
      aw_addr_reg     <= '0;
      w_data_reg      <= RST_WORD;
      w_strb_reg      <= 4'h0;
      bvalid_reg      <= 1'b0;
      bresp_reg       <= RESP_OKAY;
      rvalid_reg      <= 1'b0;
      rresp_reg       <= RESP_OKAY;
      rdata_reg       <= RST_WORD;
    end else begin
      aux_cfg_reg     <= aux_cfg_next;
      lock_cfg_reg    <= lock_cfg_next;
      dwell_time_reg  <= dwell_time_next;
      inpos_width_reg <= inpos_width_next;
      feed_cmd_reg    <= feed_cmd_next;
      block_cmd_reg   <= block_cmd_next;
      aw_held_reg     <= aw_held_next;
      w_held_reg      <= w_held_next;
      aw_addr_reg     <= aw_addr_next;
      w_data_reg      <= w_data_next;
      w_strb_reg      <= w_strb_next;
      bvalid_reg      <= bvalid_next;
      bresp_reg       <= bresp_next;
      rvalid_reg      <= rvalid_next;
      rresp_reg       <= rresp_next;
      rdata_reg       <= rdata_next;
    end
  end

  // -------------------------------------------------------------------
  // interlocks and override
  // -------------------------------------------------------------------
  logic       global_block, fast_block, ovr_zero, any_lock;
  logic [1:0] axis_block, plus_block, minus_block, inpos_ok;

  assign global_block = ~lock_cfg_reg[GLOBAL_SEL_BIT]
                        & ~pin_reg.global_lock_byte[GLOBAL_LOCK_BIT]; // R10 R11
  assign fast_block   = lock_cfg_reg[FAST_SEL_BIT]
                        & ~pin_reg.fast_lock_byte[FAST_LOCK_BIT]; // R10 R12
  assign axis_block   = {2{~lock_cfg_reg[AXIS_SEL_BIT]}} & ~pin_reg.axis_lock_n[1:0]; // R13
  assign plus_block   = {2{~lock_cfg_reg[DIR_SEL_BIT]}} & pin_reg.axis_dir_lock_plus[1:0]; // R15
  assign minus_block  = {2{~lock_cfg_reg[DIR_SEL_BIT]}} & pin_reg.axis_dir_lock_minus[1:0]; // R15
  assign any_lock     = global_block | fast_block | (|axis_block) | (|plus_block)
                        | (|minus_block);
  assign ovr_pct      = ~pin_reg.feed_override_n; // R16
  assign ovr_zero     = (ovr_pct == 8'h00);

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      // magnitude of signed servo error against the window
      inpos_ok[i] = (pos_err[i][ERR_W-1] ? (ERR_W)'(-pos_err[i]) : pos_err[i])
                    <= inpos_width_reg[ERR_W-1:0]; // R7
    end
  end

  // -------------------------------------------------------------------
  // cycle sequencer
  // -------------------------------------------------------------------
  cycle_state_type state_next;
  logic [31:0]     dwell_cnt_reg, dwell_cnt_next;
  logic [31:0]     unit_cnt_reg, unit_cnt_next;
  logic [2:0]      strobe_reg, strobe_next;
  logic [2:0]      sel_reg, sel_next;
  logic            ack_seen_reg, ack_seen_next;
  logic            ack_prev_reg;
  logic            hs_mode, aux_done;
  logic [2:0]      done_tog;
  block_kind_type  cmd_kind;

  assign hs_mode  = aux_cfg_reg[AUX_KIND_BIT]; // R2
  assign cmd_kind = block_kind_type'(block_cmd_next[CMD_KIND_LSB +: 2]);
  assign done_tog = {pin_reg.done_toggle_byte[STB_T_BIT],
                     pin_reg.done_toggle_byte[STB_S_BIT],
                     pin_reg.done_toggle_byte[STB_M_BIT]}; // R5
  // toggle form ends when every selected done input has caught up with its strobe
  assign aux_done = hs_mode ? (((done_tog ^ strobe_reg) & sel_reg) == 3'h0) // R6
                            : (ack_seen_reg & ack_prev_reg & ~pin_reg.ack_byte[ACK_BIT]); // R3

  always_comb begin
    state_next     = state_reg;
    dwell_cnt_next = dwell_cnt_reg;
    unit_cnt_next  = unit_cnt_reg;
    strobe_next    = strobe_reg;
    sel_next       = sel_reg;
    ack_seen_next  = ack_seen_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_pulse) begin
          case (cmd_kind)
            KIND_AUX: begin
              sel_next      = block_cmd_next[CMD_SEL_LSB +: 3];
              ack_seen_next = 1'b0;
              // toggle form flips the strobe, level form raises it
              strobe_next   = hs_mode ? (strobe_reg ^ sel_next) : sel_next; // R2 R4
              state_next    = ST_AUX;
            end
            KIND_DWELL: begin
              dwell_cnt_next = dwell_time_reg;
              unit_cnt_next  = 32'(DWELL_UNIT_CYCLES - 1);
              state_next     = ST_DWELL; // R8
            end
            default: state_next = ST_MOTION;
          endcase
        end
      end
      ST_AUX: begin
        if (pin_reg.ack_byte[ACK_BIT]) begin
          ack_seen_next = 1'b1;
        end
        if (aux_done) begin
          if (!hs_mode) begin
            strobe_next = 3'h0;
          end
          state_next = ST_IDLE; // R3 R6
        end
      end
      ST_MOTION: begin
        if (motion_done) begin
          state_next = (block_kind_type'(block_cmd_reg[CMD_KIND_LSB +: 2]) == KIND_POS)
                       ? ST_INPOS : ST_IDLE;
        end
      end
      ST_INPOS: begin
        if (&inpos_ok) begin
          state_next = ST_IDLE; // R7
        end
      end
      ST_DWELL: begin
        if (dwell_cnt_reg == 32'h0) begin
          state_next = ST_IDLE; // R8
        end else if (unit_cnt_reg == 32'h0) begin
          unit_cnt_next  = 32'(DWELL_UNIT_CYCLES - 1);
          dwell_cnt_next = dwell_cnt_reg - 32'h1;
        end else begin
          unit_cnt_next = unit_cnt_reg - 32'h1;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_reg     <= ST_IDLE;
      dwell_cnt_reg <= 32'h0;
      unit_cnt_reg  <= 32'h0;
      strobe_reg    <= 3'h0;
      sel_reg       <= 3'h0;
      ack_seen_reg  <= 1'b0;
      ack_prev_reg  <= 1'b0;
    end else begin
      state_reg     <= state_next;
      dwell_cnt_reg <= dwell_cnt_next;
      unit_cnt_reg  <= unit_cnt_next;
      strobe_reg    <= strobe_next;
      sel_reg       <= sel_next;
      ack_seen_reg  <= ack_seen_next;
      ack_prev_reg  <= pin_reg.ack_byte[ACK_BIT];
    end
  end

  // -------------------------------------------------------------------
  // wait flags and outputs
  // -------------------------------------------------------------------
  logic            in_motion;
  logic            run_reg;
  axis_permit_type permit_reg, permit_next;
  logic [23:0]     feed_reg;

  assign in_motion = (state_reg == ST_MOTION);

  always_comb begin
    wait_flags                = '0;
    wait_flags[FLAG_AUX]      = (state_reg == ST_AUX); // R1 R17
    wait_flags[FLAG_MOTION]   = in_motion; // R1 R17
    wait_flags[FLAG_DWELL]    = (state_reg == ST_DWELL); // R8 R17
    wait_flags[FLAG_INPOS]    = (state_reg == ST_INPOS); // R7 R17
    wait_flags[FLAG_OVR_ZERO] = in_motion & ovr_zero; // R9 R17
    wait_flags[FLAG_LOCK]     = in_motion & any_lock; // R1 R17
    wait_flags[FLAG_SPINDLE]  = in_motion & ~pin_reg.spindle_at_speed; // R1 R17
    wait_flags[FLAG_JOG_ZERO] = in_motion & pin_reg.jog_override_zero; // R1 R17
    wait_flags[FLAG_RESET]    = pin_reg.reset_active; // R1 R17
    for (int i = 0; i < 2; i++) begin
      permit_next.plus[i]  = in_motion & ~ovr_zero & ~global_block & ~fast_block
                             & ~axis_block[i] & ~plus_block[i]; // R11 R12 R13 R15
      permit_next.minus[i] = in_motion & ~ovr_zero & ~global_block & ~fast_block
                             & ~axis_block[i] & ~minus_block[i]; // R11 R12 R13 R15
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      run_reg    <= 1'b0;
      permit_reg <= '0;
      feed_reg   <= 24'h0;
    end else begin
      run_reg    <= (state_next != ST_IDLE); // R14
      permit_reg <= permit_next;
      feed_reg   <= 24'(feed_cmd_reg[15:0]) * 24'(ovr_pct); // R9
    end
  end

  always_comb begin
    code_strobe_byte            = 8'h00;
    code_strobe_byte[STB_M_BIT] = strobe_reg[SEL_M]; // R4
    code_strobe_byte[STB_S_BIT] = strobe_reg[SEL_S]; // R4
    code_strobe_byte[STB_T_BIT] = strobe_reg[SEL_T]; // R4
  end

  assign running_indicator = run_reg;
  assign axis_permit       = permit_reg;
  assign motion_active     = in_motion;
  assign feed_scaled       = feed_reg;
endmodule

// ### sim/wait_checker.sv
// port assertions for the automatic-cycle wait interlock
`timescale 1ns/10ps
module wait_checker
  import wait_interlock_pkg::*;
(
  input wire logic ref_clk, srst, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
  input wire logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid,
  input wire logic s_axi_arready, s_axi_rvalid, s_axi_rready,
  input wire logic motion_active, running_indicator,
  input wire logic [1:0] s_axi_bresp, s_axi_rresp,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [7:0] code_strobe_byte,
  input wire logic [23:0] feed_scaled,
  input wire pin_in_type pins
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> s_axi_bvalid) else $error("write not answered");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
  a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h20
    |=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR) else $error("unmapped read not refused");
  a_strobe_bits: assert property (code_strobe_byte[7:4] == 4'h0 && !code_strobe_byte[1])
    else $error("strobe on unused bit");
  a_override_zero: assert property (pins.feed_override_n == 8'hFF [*4] |-> feed_scaled == 24'h0)
    else $error("zero override still feeds");
  a_motion_run: assert property (motion_active |-> running_indicator)
    else $error("motion without running indicator");
  cover property ($fell(running_indicator));
  cover property (code_strobe_byte[0]);
  cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule
bind auto_cycle_wait_interlock wait_checker wait_checker_i (.*);

// ### sim/plc_model.sv
// machine-logic model answering the aux strobes in level or toggle form
`timescale 1ns/10ps
module plc_model (
  input wire logic ref_clk, srst, toggle_mode,
  input wire logic [7:0] strobe_byte,
  input wire logic [3:0] delay,
  output logic [7:0] ack_byte, done_byte
);
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] ack_next, done_next;
  logic phase_reg, phase_next;
  always_comb begin
    cnt_next = cnt_reg + 4'h1;
    ack_next = ack_byte;
    done_next = done_byte;
    phase_next = phase_reg;
    if (toggle_mode) begin
      if (done_byte == (strobe_byte & 8'h0D)) cnt_next = 4'h0;
      else if (cnt_reg >= delay) done_next = strobe_byte & 8'h0D;
    end else if (strobe_byte == 8'h00) begin
      phase_next = 1'b0;
      cnt_next = 4'h0;
    end else if (!phase_reg && cnt_reg >= delay) begin
      // raise the finish bit, later drop it, then wait for strobes to clear
      ack_next = ack_byte ^ 8'h08;
      cnt_next = 4'h0;
      phase_next = ack_byte[3];
    end
  end
  always_ff @(posedge ref_clk) begin
    if (srst) {cnt_reg, ack_byte, done_byte, phase_reg} <= '0;
    else {cnt_reg, ack_byte, done_byte, phase_reg} <= {cnt_next, ack_next, done_next, phase_next};
  end
endmodule

// ### sim/test_auto_cycle_wait_interlock.sv
// self-checking bench of the automatic-cycle wait interlock
`timescale 1ns/10ps
module test_auto_cycle_wait_interlock;
  import wait_interlock_pkg::*;
  logic ref_clk, srst, awv, wv, bre, arv, rre, mode, aw_rdy, w_rdy, b_v, ar_rdy, r_v, ma, run;
  logic [7:0] awa, ara, stb, ack_w, done_w;
  logic mdone;
  logic [31:0] wd, r_d, rdat, perr;
  logic [1:0] b_r, r_r, resp;
  logic [23:0] fs;
  axis_permit_type permit;
  pin_in_type drv;
  wire pin_in_type pins = {ack_w, done_w, drv[50:0]};
  int fail_count, comparisons, cycles;
  auto_cycle_wait_interlock #(.DWELL_UNIT_CYCLES(4)) auto_cycle_wait_interlock_i (
    .ref_clk(ref_clk), .srst(srst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(aw_rdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(w_rdy), .s_axi_bresp(b_r), .s_axi_bvalid(b_v), .s_axi_bready(bre),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(ar_rdy), .s_axi_rdata(r_d),
    .s_axi_rresp(r_r), .s_axi_rvalid(r_v), .s_axi_rready(rre), .pins(pins),
    .motion_done(mdone), .pos_err(perr), .code_strobe_byte(stb), .axis_permit(permit),
    .motion_active(ma), .feed_scaled(fs), .running_indicator(run));
  plc_model plc_model_i (.ref_clk(ref_clk), .srst(srst), .toggle_mode(mode),
    .strobe_byte(stb), .delay(4'h3), .ack_byte(ack_w), .done_byte(done_w));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      stop_test;
    end
  end
  task stop_test;
    if (fail_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    tb = 1'b0;
    awa <= a;
    wd <= d;
    {awv, wv, bre} <= 3'h7;
    while (!tb) begin
      @(negedge ref_clk);
      {ta, tw, tb, resp} = {awv && aw_rdy, wv && w_rdy, bre && b_v, b_r};
      @(posedge ref_clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end
    bre <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    tr = 1'b0;
    ara <= a;
    {arv, rre} <= 2'h3;
    while (!tr) begin
      @(negedge ref_clk);
      {ta, tr, rdat, resp} = {arv && ar_rdy, rre && r_v, r_d, r_r};
      @(posedge ref_clk);
      if (ta) arv <= 1'b0;
    end
    rre <= 1'b0;
    @(posedge ref_clk);
  endtask
  task idle;
    do @(negedge ref_clk); while (run !== 1'b0);
    @(posedge ref_clk);
  endtask
  task settle;
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task t_aux(input logic [31:0] kind, cmd, input logic [7:0] s0, s1);
    mode <= kind[7];
    wr(OFF_AUX_CFG, kind);
    wr(OFF_BLOCK_CMD, cmd);
    @(negedge ref_clk);
    chk(stb, s0);
    @(posedge ref_clk);
    rd(OFF_STATUS);
    chk(rdat & 32'h10001, 32'h10001);
    idle;
    chk(stb, s1);
  endtask
  task t_dwell;
    wr(OFF_DWELL_TIME, 32'h5);
    wr(OFF_BLOCK_CMD, 32'h2);
    rd(OFF_STATUS);
    chk(rdat & 32'h10004, 32'h10004);
    idle;
  endtask
  task t_ovr(input logic [7:0] n, input logic [31:0] e);
    drv.feed_override_n <= n;
    settle;
    @(posedge ref_clk);
    rd(OFF_OVERRIDE);
    chk(rdat, e);
    chk({8'h0, fs}, e >> 8);
  endtask
  task pchk(input logic [3:0] e);
    settle;
    chk({28'h0, permit}, {28'h0, e});
    @(posedge ref_clk);
    drv <= {64'h0000_FFFF_FF00_009B, 3'h0};
    @(posedge ref_clk);
  endtask
  initial begin
    drv = {64'h0000_FFFF_FF00_009B, 3'h0};
    {srst, mdone, perr, awv, wv, bre, arv, rre, mode, awa, ara, wd} = {1'b1, 87'h0};
    repeat (10) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    rd(OFF_AUX_CFG);
    chk(rdat, RST_WORD);
    rd(8'h40);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR});
    wr(8'h40, 32'h0);
    chk(32'(resp), 32'(RESP_SLVERR));
    t_aux(32'h00, 32'h07, 8'h01, 8'h00);
    t_aux(32'h80, 32'h1F, 8'h0D, 8'h0D);
    t_aux(32'h80, 32'h07, 8'h0C, 8'h0C);
    t_dwell;
    wr(OFF_FEED_CMD, 32'h64);
    t_ovr(8'h9B, 32'h0027_1064);
    t_ovr(8'hFF, 32'h0);
    t_ovr(8'h9B, 32'h0027_1064);
    wr(OFF_LOCK_CFG, 32'h0);
    wr(OFF_BLOCK_CMD, 32'h0);
    pchk(4'hF);
    chk({30'h0, ma, run}, 32'h3);
    drv.global_lock_byte <= 8'hFE;
    pchk(4'h0);
    drv.axis_lock_n <= 8'hFE;
    pchk(4'hA);
    drv.axis_dir_lock_plus <= 8'h02;
    pchk(4'h7);
    wr(OFF_LOCK_CFG, 32'h2);
    drv.fast_lock_byte <= 8'hBF;
    pchk(4'h0);
    mdone <= 1'b1;
    idle;
    perr <= 32'h0009_0000;
    wr(OFF_INPOS_WIDTH, 32'h8);
    wr(OFF_BLOCK_CMD, 32'h1);
    rd(OFF_STATUS);
    chk(rdat & 32'h8, 32'h8);
    perr <= 32'h0008_FFF8;
    idle;
    stop_test;
  end
endmodule
